// >>> hdl/pmbp_defs.svh
/*
 * constants for the bus-master burst policy: register offsets, field bits,
 * reset values and the two cache line sizes that allow write-and-invalidate.
 * assumes it is included by bare name from hdl/.
 */
`ifndef PMBP_DEFS_SVH
`define PMBP_DEFS_SVH
// register byte offsets
`define PMBP_OFS_CFG     5'h00
`define PMBP_OFS_CMD     5'h04
`define PMBP_OFS_CLS     5'h08
`define PMBP_OFS_STAT    5'h0c
`define PMBP_OFS_PWR     5'h10
// device configuration bits
`define PMBP_CFG_MWI     0
`define PMBP_CFG_RDALN   2
`define PMBP_CFG_TERMW   3
`define PMBP_CFG_CRDIS   4
// host command register bits
`define PMBP_CMD_MWI     4
`define PMBP_CMD_PERESP  6
// status bits
`define PMBP_ST_CLKON    0
`define PMBP_ST_PME      1
`define PMBP_ST_DPD      8
`define PMBP_ST_DPE      15
// reset values and sizes
`define PMBP_RST_CFG     32'h0000_0000
`define PMBP_RST_CMD     32'h0000_0000
`define PMBP_RST_CLS     8'h00
`define PMBP_CLS_A       8'h08
`define PMBP_CLS_B       8'h10
`define PMBP_PWR_D0      2'h0
`define PMBP_RESP_OK     2'h0
`define PMBP_RESP_ERR    2'h2
`endif

// >>> hdl/pmbp_pkg.sv
/*
 * types for the bus-master burst policy.
 * assumes nothing beyond a systemverilog compiler.
 */
package pmbp_pkg;
	// burst engine phases
	typedef enum logic [0:0] {PMBP_IDLE, PMBP_BURST} pmbp_state_t;
	// one burst decision towards the bus sequencer
	typedef struct packed {
		logic       busy;   // burst under way
		logic       mwi;    // write-and-invalidate command
		logic       stop;   // one-cycle end of burst
		logic [3:0] be_n;   // byte enables, active low
	} pmbp_burst_t;
endpackage

// >>> hdl/pmbp_top.sv
/*
 * bus-master burst policy: command choice and burst ends on cache lines for
 * receive writes and transmit reads, master parity report, clock request and
 * wake signalling, with an axi4-lite register file.
 * assumes a bus sequencer that reports each dword moved and obeys stop pulses.
 */
// Contract
// R1 - invalidate bursts move whole lines, all enables
// R2 - cross a line only to move next
// R3 - invalidate only with line size 8 or 16
// R4 - invalidate starts on a line boundary
// R5 - receive fifo holds a full line
// R6 - host buffer has room for a line
// R7 - both invalidate enables must be set
// R8 - otherwise use plain memory write
// R9 - lapsed condition ends burst at line end
// R10 - terminate-write bit ends plain write at boundary
// R11 - read align ends reads on boundaries
// R12 - fifo nearly full stops at nearest boundary
// R13 - max count hands over only at boundaries
// R14 - software uses read align only for 8/16
// R15 - control fetches start at first dword
// R16 - parity error asserts error pin, status 8
// R17 - read parity error also sets status 15
// R18 - host drops clock request before stopping clock
// R19 - device drives clock request when needing clock
// R20 - host restores clock within half microsecond
// R21 - clock run disabled keeps requesting always
// R22 - wake events drive the wake output
// R23 - bus mastering only in full power state
`timescale 1ns/1ns
`default_nettype none
`include "pmbp_defs.svh"
module pmbp_top (
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        arst_n_i,
	// axi4-lite slave
	input  wire logic [4:0]  s_awaddr_i,
	input  wire logic        s_awvalid_i,
	output logic             s_awready_o,
	input  wire logic [31:0] s_wdata_i,
	input  wire logic [3:0]  s_wstrb_i,
	input  wire logic        s_wvalid_i,
	output logic             s_wready_o,
	output logic [1:0]       s_bresp_o,
	output logic             s_bvalid_o,
	input  wire logic        s_bready_i,
	input  wire logic [4:0]  s_araddr_i,
	input  wire logic        s_arvalid_i,
	output logic             s_arready_o,
	output logic [31:0]      s_rdata_o,
	output logic [1:0]       s_rresp_o,
	output logic             s_rvalid_o,
	input  wire logic        s_rready_i,
	// receive write side
	input  wire logic        wr_req_i,
	input  wire logic [29:0] wr_addr_i,
	input  wire logic        wr_dphase_i,
	input  wire logic [11:0] rx_fifo_dw_i,
	input  wire logic [15:0] buf_space_dw_i,
	output pmbp_pkg::pmbp_burst_t wr_o,
	// transmit read side
	input  wire logic        rd_req_i,
	input  wire logic [29:0] rd_addr_i,
	input  wire logic        rd_dphase_i,
	input  wire logic        tx_almost_full_i,
	input  wire logic        tx_maxcnt_i,
	output pmbp_pkg::pmbp_burst_t rd_o,
	// control structure fetch
	input  wire logic        ctl_req_i,
	input  wire logic [29:0] ctl_base_i,
	output logic [29:0]      ctl_addr_o,
	output logic             ctl_go_o,
	// parity
	input  wire logic        par_err_i,
	input  wire logic        par_rd_i,
	output logic             perr_n_o,
	output logic             perr_oe_n_o,
	// clock request, open drain
	input  wire logic        clkrun_n_i,
	input  wire logic        need_clk_i,
	output logic             clkrun_n_o,
	output logic             clkrun_oe_n_o,
	// wake
	input  wire logic        wake_evt_i,
	output logic             pme_n_o,
	output logic             pme_oe_n_o
);
	logic        rst_s1_q, rst_n_q;          // reset release pair
	logic [31:0] cfg_q, cmd_q;               // configuration words
	logic [7:0]  cls_q;                      // cache line size in dwords
	logic [1:0]  pwr_q;                      // power state
	logic        dpd_q, dpe_q, pme_q;        // sticky status
	logic        ck_s1_q, ck_s2_q;           // clock request sampled back
	logic        aw_q, w_q;                  // write halves captured
	logic [4:0]  awa_q;
	logic [31:0] wd_q;
	pmbp_pkg::pmbp_state_t wst_q, rst_q;     // engine states
	logic [7:0]  woff_q, roff_q;             // dword offset inside line
	logic        wmwi_q, wlapse_q;           // command, line ends burst
	logic        rpend_q;                    // read wants to stop at boundary
	logic        d0, wdo, wclr, st_w1;
	logic [31:0] st_rd;

	// line size is one of the two legal ones
	function automatic logic cls_ok(input logic [7:0] c);
		cls_ok = (c == `PMBP_CLS_A) || (c == `PMBP_CLS_B);
	endfunction
	// offset of a dword address inside the current line
	function automatic logic [7:0] line_off(input logic [29:0] a, input logic [7:0] c);
		line_off = a[7:0] & (c - 8'h01);
	endfunction

	// reset released through two flops
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// R23 full power gate
	assign d0 = (pwr_q == `PMBP_PWR_D0);

	// all invalidate preconditions except alignment, reused every line
	function automatic logic mwi_ok(input logic [7:0] c, input logic [11:0] f,
		input logic [15:0] s, input logic ce, input logic he);
		// R3 size, R5 fifo, R6 room, R7 both enables
		mwi_ok = cls_ok(c) && (f >= {4'h0, c}) && (s >= {8'h00, c}) && ce && he;
	endfunction

	logic elig_now;
	assign elig_now = mwi_ok(cls_q, rx_fifo_dw_i, buf_space_dw_i,
		cfg_q[`PMBP_CFG_MWI], cmd_q[`PMBP_CMD_MWI]);

	// axi write address and data, taken in either order
	assign wdo = aw_q && w_q && !s_bvalid_o;
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			aw_q        <= 1'b0;
			w_q         <= 1'b0;
			awa_q       <= 5'h00;
			wd_q        <= 32'h0000_0000;
			s_awready_o <= 1'b0;
			s_wready_o  <= 1'b0;
			s_bvalid_o  <= 1'b0;
			s_bresp_o   <= `PMBP_RESP_OK;
		end else begin
			s_awready_o <= !aw_q && !s_awready_o;
			s_wready_o  <= !w_q && !s_wready_o;
			if (s_awvalid_i && s_awready_o) begin
				aw_q  <= 1'b1;
				awa_q <= s_awaddr_i;
				s_awready_o <= 1'b0;
			end
			if (s_wvalid_i && s_wready_o) begin
				w_q  <= 1'b1;
				wd_q <= s_wdata_i;
				s_wready_o <= 1'b0;
			end
			// answer once both halves are in
			if (wdo) begin
				s_bvalid_o <= 1'b1;
				s_bresp_o  <= (awa_q > `PMBP_OFS_PWR) ? `PMBP_RESP_ERR : `PMBP_RESP_OK;
			end
			if (s_bvalid_o && s_bready_i) begin
				s_bvalid_o <= 1'b0;
				aw_q <= 1'b0;
				w_q  <= 1'b0;
			end
		end
	end

	// register writes; whole words, strobes ignored for simplicity
	assign st_w1 = wdo && (awa_q == `PMBP_OFS_STAT);
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cfg_q <= `PMBP_RST_CFG;
			cmd_q <= `PMBP_RST_CMD;
			cls_q <= `PMBP_RST_CLS;
			pwr_q <= `PMBP_PWR_D0;
		end else if (wdo) begin
			case (awa_q)
				`PMBP_OFS_CFG: cfg_q <= wd_q;
				`PMBP_OFS_CMD: cmd_q <= wd_q;
				`PMBP_OFS_CLS: cls_q <= wd_q[7:0];
				`PMBP_OFS_PWR: pwr_q <= wd_q[1:0];
				default: ;
			endcase
		end
	end

	// axi reads, data one cycle after the address is taken
	assign st_rd = {16'h0000, dpe_q, 6'h00, dpd_q, 6'h00, pme_q, ck_s2_q};
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			s_arready_o <= 1'b0;
			s_rvalid_o  <= 1'b0;
			s_rdata_o   <= 32'h0000_0000;
			s_rresp_o   <= `PMBP_RESP_OK;
		end else begin
			s_arready_o <= !s_rvalid_o && !s_arready_o;
			if (s_arvalid_i && s_arready_o) begin
				s_arready_o <= 1'b0;
				s_rvalid_o  <= 1'b1;
				s_rresp_o   <= `PMBP_RESP_OK;
				case (s_araddr_i)
					`PMBP_OFS_CFG:  s_rdata_o <= cfg_q;
					`PMBP_OFS_CMD:  s_rdata_o <= cmd_q;
					`PMBP_OFS_CLS:  s_rdata_o <= {24'h000000, cls_q};
					`PMBP_OFS_STAT: s_rdata_o <= st_rd;
					`PMBP_OFS_PWR:  s_rdata_o <= {30'h0000_0000, pwr_q};
					default: begin
						s_rdata_o <= 32'h0000_0000;
						s_rresp_o <= `PMBP_RESP_ERR;
					end
				endcase
			end else if (s_rvalid_o && s_rready_i) begin
				s_rvalid_o <= 1'b0;
			end
		end
	end

	// receive write engine; offset counts dwords moved inside the line
	assign wclr = wr_dphase_i && (woff_q == cls_q - 8'h01);
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wst_q    <= pmbp_pkg::PMBP_IDLE;
			wmwi_q   <= 1'b0;
			wlapse_q <= 1'b0;
			woff_q   <= 8'h00;
			wr_o     <= '{busy: 1'b0, mwi: 1'b0, stop: 1'b0, be_n: 4'h0};
		end else begin
			wr_o.stop <= 1'b0;
			case (wst_q)
				pmbp_pkg::PMBP_IDLE: begin
					// R23 only in full power
					if (wr_req_i && d0) begin
						wst_q  <= pmbp_pkg::PMBP_BURST;
						woff_q <= cls_ok(cls_q) ? line_off(wr_addr_i, cls_q) : 8'h00;
						// R4 aligned start, R8 else plain write
						wmwi_q <= elig_now && (line_off(wr_addr_i, cls_q) == 8'h00);
						wr_o.mwi  <= elig_now && (line_off(wr_addr_i, cls_q) == 8'h00);
						wr_o.busy <= 1'b1;
						// R1 every enable active
						wr_o.be_n <= 4'h0;
						wlapse_q  <= 1'b0;
					end
				end
				pmbp_pkg::PMBP_BURST: begin
					// R9 note a lapse, act at the line end
					if (wmwi_q && !elig_now)
						wlapse_q <= 1'b1;
					if (wr_dphase_i)
						woff_q <= wclr ? 8'h00 : woff_q + 8'h01;
					// R2 cross only when the next line goes too
					if (wclr && wmwi_q && (wlapse_q || !elig_now || !wr_req_i)) begin
						wst_q <= pmbp_pkg::PMBP_IDLE;
						wr_o.busy <= 1'b0;
						wr_o.stop <= 1'b1;
					// R10 terminate plain write at boundary
					end else if (wclr && !wmwi_q && cfg_q[`PMBP_CFG_TERMW]) begin
						wst_q <= pmbp_pkg::PMBP_IDLE;
						wr_o.busy <= 1'b0;
						wr_o.stop <= 1'b1;
					// plain writes may end anywhere once data runs out
					end else if (!wmwi_q && !wr_req_i) begin
						wst_q <= pmbp_pkg::PMBP_IDLE;
						wr_o.busy <= 1'b0;
						wr_o.stop <= 1'b1;
					end
				end
				default: wst_q <= pmbp_pkg::PMBP_IDLE;
			endcase
		end
	end

	// transmit read engine
	logic rclr, rwant;
	assign rclr  = rd_dphase_i && (roff_q == cls_q - 8'h01);
	assign rwant = tx_almost_full_i || tx_maxcnt_i || !rd_req_i;
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rst_q   <= pmbp_pkg::PMBP_IDLE;
			roff_q  <= 8'h00;
			rpend_q <= 1'b0;
			rd_o    <= '{busy: 1'b0, mwi: 1'b0, stop: 1'b0, be_n: 4'h0};
		end else begin
			rd_o.stop <= 1'b0;
			case (rst_q)
				pmbp_pkg::PMBP_IDLE: begin
					if (rd_req_i && d0) begin
						rst_q     <= pmbp_pkg::PMBP_BURST;
						roff_q    <= line_off(rd_addr_i, cls_q);
						rpend_q   <= 1'b0;
						rd_o.busy <= 1'b1;
					end
				end
				pmbp_pkg::PMBP_BURST: begin
					if (rd_dphase_i)
						roff_q <= rclr ? 8'h00 : roff_q + 8'h01;
					if (rwant)
						rpend_q <= 1'b1;
					// R11 R12 R13 aligned: stop on the boundary only
					if (cfg_q[`PMBP_CFG_RDALN] && cls_ok(cls_q)) begin
						if (rclr && (rpend_q || rwant)) begin
							rst_q     <= pmbp_pkg::PMBP_IDLE;
							rd_o.busy <= 1'b0;
							rd_o.stop <= 1'b1;
						end
					end else if (rwant) begin
						rst_q     <= pmbp_pkg::PMBP_IDLE;
						rd_o.busy <= 1'b0;
						rd_o.stop <= 1'b1;
					end
				end
				default: rst_q <= pmbp_pkg::PMBP_IDLE;
			endcase
		end
	end

	// R15 fetch from the first dword of the structure
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctl_addr_o <= 30'h0000_0000;
			ctl_go_o   <= 1'b0;
		end else begin
			ctl_go_o <= ctl_req_i && d0;
			if (ctl_req_i && d0)
				ctl_addr_o <= ctl_base_i;
		end
	end

	// master parity report; a new error beats a clear
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dpd_q       <= 1'b0;
			dpe_q       <= 1'b0;
			perr_n_o    <= 1'b1;
			perr_oe_n_o <= 1'b1;
		end else begin
			// R16 pin and status 8
			perr_n_o    <= !(par_err_i && cmd_q[`PMBP_CMD_PERESP]);
			perr_oe_n_o <= !(par_err_i && cmd_q[`PMBP_CMD_PERESP]);
			if (par_err_i && cmd_q[`PMBP_CMD_PERESP])
				dpd_q <= 1'b1;
			else if (st_w1 && wd_q[`PMBP_ST_DPD])
				dpd_q <= 1'b0;
			// R17 reads set status 15
			if (par_err_i && par_rd_i)
				dpe_q <= 1'b1;
			else if (st_w1 && wd_q[`PMBP_ST_DPE])
				dpe_q <= 1'b0;
		end
	end

	// clock request; the host side level is sampled back for software
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			clkrun_n_o    <= 1'b0;
			clkrun_oe_n_o <= 1'b0;
			ck_s1_q       <= 1'b0;
			ck_s2_q       <= 1'b0;
		end else begin
			clkrun_n_o <= 1'b0;
			// R19 R21 drive low while the clock is needed
			clkrun_oe_n_o <= !(need_clk_i || wr_o.busy || rd_o.busy || cfg_q[`PMBP_CFG_CRDIS]);
			ck_s1_q <= !clkrun_n_i;
			ck_s2_q <= ck_s1_q;
		end
	end

	// R22 wake held until software clears it; event beats clear
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pme_q      <= 1'b0;
			pme_n_o    <= 1'b1;
			pme_oe_n_o <= 1'b1;
		end else begin
			if (wake_evt_i)
				pme_q <= 1'b1;
			else if (st_w1 && wd_q[`PMBP_ST_PME])
				pme_q <= 1'b0;
			pme_n_o    <= !(wake_evt_i || pme_q);
			pme_oe_n_o <= !(wake_evt_i || pme_q);
		end
	end

	// checks
	a_mwi_be_all: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R1
		wr_o.busy && wr_o.mwi |-> wr_o.be_n == 4'h0) else $error("mwi enables not all on");
	a_mwi_line_end: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R2
		wr_o.stop && $past(wmwi_q) |-> $past(wclr)) else $error("mwi ended mid line");
	a_mwi_size: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R3
		$rose(wr_o.busy) && wr_o.mwi |-> $past(cls_ok(cls_q))) else $error("mwi with bad size");
	a_mwi_aligned: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R4
		$rose(wr_o.busy) && wr_o.mwi |-> woff_q == 8'h00) else $error("mwi start unaligned");
	a_mwi_fifo: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R5
		$rose(wr_o.busy) && wr_o.mwi |-> $past(rx_fifo_dw_i) >= {4'h0, $past(cls_q)})
		else $error("mwi without line in fifo");
	a_mwi_enables: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R7
		$rose(wr_o.busy) && wr_o.mwi |-> $past(cmd_q[`PMBP_CMD_MWI] && cfg_q[`PMBP_CFG_MWI]))
		else $error("mwi without enables");
	a_termw_stop: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R10
		wst_q == pmbp_pkg::PMBP_BURST && !wmwi_q && wclr && cfg_q[`PMBP_CFG_TERMW]
		|=> wr_o.stop && !wr_o.busy) else $error("plain write not cut");
	a_rdaln_stop: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R11
		rd_o.stop && $past(cfg_q[`PMBP_CFG_RDALN] && cls_ok(cls_q)) |-> $past(rclr))
		else $error("aligned read off boundary");
	a_perr_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R16
		par_err_i && cmd_q[`PMBP_CMD_PERESP] |=> !perr_oe_n_o && dpd_q) else $error("perr missing");
	a_dpe_read: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R17
		par_err_i && par_rd_i |=> dpe_q) else $error("status 15 not set");
	a_clk_hold: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R21
		cfg_q[`PMBP_CFG_CRDIS] |=> !clkrun_oe_n_o) else $error("clock not requested");
	a_wake_out: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R22
		wake_evt_i |=> !pme_oe_n_o [*2]) else $error("wake not signalled");
	a_power_gate: assert property (@(posedge clock_i) disable iff (!rst_n_q) // R23
		!d0 && wst_q == pmbp_pkg::PMBP_IDLE |=> !wr_o.busy) else $error("master out of d0");
	c_mwi_burst: cover property (@(posedge clock_i) disable iff (!rst_n_q) $rose(wr_o.busy) && wr_o.mwi);
	c_mw_cut: cover property (@(posedge clock_i) disable iff (!rst_n_q) wr_o.stop && !wmwi_q);
	c_rd_align: cover property (@(posedge clock_i) disable iff (!rst_n_q) rd_o.stop && cfg_q[`PMBP_CFG_RDALN]);
endmodule // pmbp_top
`default_nettype wire

// >>> dv/pmbp_host_model.sv
/*
 * host side model: memory data phases for both bursts and the clock line.
 * assumes the bench resolves the open-drain clock line from this level and the device enable.
 */
`timescale 1ns/1ns
`default_nettype none
module pmbp_host_model (
	// clock and pacing
	input  wire logic clock_i,
	input  wire logic slow_i,
	// device burst state
	input  wire logic wr_busy_i,
	input  wire logic rd_busy_i,
	// data phases and host clock drive
	output logic      wr_dphase_o,
	output logic      rd_dphase_o,
	output logic      clkrun_n_o
);
	logic stall_q = 1'b0; // wait state on every other phase when slow

	// slow memory inserts a wait state between dwords
	always_ff @(posedge clock_i) begin
		stall_q <= slow_i & ~stall_q;
	end

	// memory moves a dword each cycle the burst stays open, except on a wait state
	assign wr_dphase_o = wr_busy_i & ~stall_q;
	assign rd_dphase_o = rd_busy_i & ~stall_q;

	// clock never stopped, so no restore delay
	// host keeps clock
	// the clock never stops here, so the host keeps the line asserted
	assign clkrun_n_o = 1'b0;
endmodule // pmbp_host_model
`default_nettype wire

// >>> dv/testbench.sv
/*
 * self-checking bench for the burst policy: command choice table, burst ends,
 * parity, clock request, wake, power state and register bus.
 * assumes the host model beside it answers every data phase.
 */
`timescale 1ns/1ns
`default_nettype none
`include "pmbp_defs.svh"
module testbench;
	typedef struct {logic [7:0] cls, cfg, cmd, adr; logic [15:0] fifo, spc; logic mwi;} pmbp_row_t;
	logic clock_i = 1'b0, arst_n_i = 1'b0;
	logic [4:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic wr_req = 0, rd_req = 0, tx_af = 0, tx_max = 0, ctl_req = 0, par_err = 0, par_rd = 0;
	logic need_clk = 0, wake = 0, slow = 0;
	logic [29:0] wr_addr = '0, ctl_base = '0;
	logic [11:0] fifo = '0;
	logic [15:0] space = '0;
	wire logic awready, wready, bvalid, arready, rvalid, wr_dph, rd_dph, host_clk_n, clk_line;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [29:0] ctl_addr;
	wire logic ctl_go, perr_n, perr_oe_n, clkrun_n, clkrun_oe_n, pme_n, pme_oe_n;
	pmbp_pkg::pmbp_burst_t wr_o, rd_o;
	int cnt_w = 0, cnt_r = 0, mismatches = 0, check_count = 0, cnt;
	logic m;
	logic [31:0] d;
	logic [1:0] r;
	// command choice cases: line size, config, command, start, fifo, space, invalidate
	pmbp_row_t rows [9] = '{
		'{8'h08, 8'h01, 8'h10, 8'h00, 16'd8, 16'd8, 1'b1},
		'{8'h10, 8'h01, 8'h10, 8'h00, 16'd16, 16'd16, 1'b1},
		'{8'h0c, 8'h01, 8'h10, 8'h00, 16'd16, 16'd16, 1'b0},
		'{8'h08, 8'h01, 8'h10, 8'h04, 16'd8, 16'd8, 1'b0},
		'{8'h08, 8'h01, 8'h10, 8'h00, 16'd7, 16'd8, 1'b0},
		'{8'h08, 8'h01, 8'h10, 8'h00, 16'd8, 16'd7, 1'b0},
		'{8'h08, 8'h01, 8'h00, 8'h00, 16'd8, 16'd8, 1'b0},
		'{8'h08, 8'h00, 8'h10, 8'h00, 16'd8, 16'd8, 1'b0},
		'{8'h10, 8'h01, 8'h10, 8'h08, 16'd16, 16'd16, 1'b0}};

	// open-drain clock line: low if either party drives it
	assign clk_line = host_clk_n & (clkrun_oe_n ? 1'b1 : clkrun_n);

	pmbp_top i_dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
		.s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata),
		.s_wstrb_i(4'hf), .s_wvalid_i(wvalid), .s_wready_o(wready), .s_bresp_o(bresp),
		.s_bvalid_o(bvalid), .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
		.s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
		.s_rready_i(rready), .wr_req_i(wr_req), .wr_addr_i(wr_addr), .wr_dphase_i(wr_dph),
		.rx_fifo_dw_i(fifo), .buf_space_dw_i(space), .wr_o(wr_o), .rd_req_i(rd_req),
		.rd_addr_i(30'h0), .rd_dphase_i(rd_dph), .tx_almost_full_i(tx_af), .tx_maxcnt_i(tx_max),
		.rd_o(rd_o), .ctl_req_i(ctl_req), .ctl_base_i(ctl_base), .ctl_addr_o(ctl_addr),
		.ctl_go_o(ctl_go), .par_err_i(par_err), .par_rd_i(par_rd), .perr_n_o(perr_n),
		.perr_oe_n_o(perr_oe_n), .clkrun_n_i(clk_line), .need_clk_i(need_clk),
		.clkrun_n_o(clkrun_n), .clkrun_oe_n_o(clkrun_oe_n), .wake_evt_i(wake),
		.pme_n_o(pme_n), .pme_oe_n_o(pme_oe_n));

	pmbp_host_model i_host (.clock_i(clock_i), .slow_i(slow), .wr_busy_i(wr_o.busy),
		.rd_busy_i(rd_o.busy), .wr_dphase_o(wr_dph), .rd_dphase_o(rd_dph), .clkrun_n_o(host_clk_n));

	// clock, 10 ns period
	initial begin
		forever #5 clock_i = ~clock_i;
	end

	// dwords moved in each burst
	always @(posedge clock_i) begin
		if (wr_o.busy && wr_dph) cnt_w <= cnt_w + 1;
		if (rd_o.busy && rd_dph) cnt_r <= cnt_r + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// write one word; both halves offered together, released when taken
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clock_i);
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (n < 50) begin
			@(posedge clock_i);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp; bready <= 1'b0; break;
			end
		end
		if (n == 50) mismatches++;
	endtask

	task automatic axi_rd(input logic [4:0] a);
		int n;
		n = 0;
		@(posedge clock_i);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (n < 50) begin
			@(posedge clock_i);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata; r = rresp; rready <= 1'b0; break;
			end
		end
		if (n == 50) mismatches++;
	endtask

	task automatic reg_chk(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
		axi_rd(a);
		check(d, e);
		check(r, er);
	endtask

	// one burst; at dword count 'at' the event 'kind' occurs: 0 request drops,
	// 1 host space runs out and tx fifo nearly full, 2 max count reached
	task automatic run(input bit rd, input int kind, input int at);
		int n;
		n = 0;
		cnt_w = 0; cnt_r = 0; m = 1'bx;
		@(posedge clock_i);
		if (rd) rd_req <= 1'b1;
		else wr_req <= 1'b1;
		while (n < 300) begin
			@(posedge clock_i);
			n++;
			if (rd ? rd_o.busy : wr_o.busy) m = rd ? rd_o.mwi : wr_o.mwi;
			if ((rd ? cnt_r : cnt_w) == at) begin
				case (kind)
					0: begin wr_req <= 1'b0; rd_req <= 1'b0; end
					1: begin space <= '0; tx_af <= 1'b1; end
					default: tx_max <= 1'b1;
				endcase
			end
			if (rd ? rd_o.stop : wr_o.stop) break;
		end
		cnt = rd ? cnt_r : cnt_w;
		wr_req <= 1'b0; rd_req <= 1'b0; tx_af <= 1'b0; tx_max <= 1'b0;
		if (n == 300) mismatches++;
		// a restart taken at the stop edge must run out before the next case
		repeat (40) @(posedge clock_i);
	endtask

	// watchdog: the whole sequence needs about a thousand cycles
	initial begin
		#400000;
		mismatches++;
		conclude();
	end

	initial begin
		repeat (6) @(posedge clock_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		reg_chk(`PMBP_OFS_CFG, `PMBP_RST_CFG, `PMBP_RESP_OK);
		reg_chk(`PMBP_OFS_CMD, `PMBP_RST_CMD, `PMBP_RESP_OK);
		reg_chk(`PMBP_OFS_CLS, 32'h0, `PMBP_RESP_OK);
		reg_chk(5'h14, 32'h0, `PMBP_RESP_ERR);
		axi_wr(5'h14, 32'hffff_ffff);
		check(r, `PMBP_RESP_ERR);
		foreach (rows[i]) begin
			axi_wr(`PMBP_OFS_CFG, {24'h0, rows[i].cfg});
			axi_wr(`PMBP_OFS_CMD, {24'h0, rows[i].cmd});
			axi_wr(`PMBP_OFS_CLS, {24'h0, rows[i].cls});
			wr_addr <= {22'h0, rows[i].adr}; fifo <= rows[i].fifo[11:0]; space <= rows[i].spc;
			slow <= i[0];
			run(1'b0, 0, 0);
			check(m, rows[i].mwi);
			check(wr_o.be_n, 4'h0);
			if (rows[i].mwi) check(cnt, rows[i].cls);
		end
		slow <= 1'b0;
		// space lapses mid-line: invalidate burst still ends at line end
		axi_wr(`PMBP_OFS_CLS, 32'h8);
		wr_addr <= '0; fifo <= 12'd64; space <= 16'd64;
		run(1'b0, 1, 3);
		check(cnt, 32'd8);
		// plain write with terminate bit ends at the line
		axi_wr(`PMBP_OFS_CMD, 32'h0);
		axi_wr(`PMBP_OFS_CFG, 32'h1 << `PMBP_CFG_TERMW);
		run(1'b0, 2, 1000);
		check(cnt, 32'd8);
		axi_wr(`PMBP_OFS_CFG, 32'h0);
		run(1'b0, 0, 12);
		check(cnt >= 12, 1'b1);
		// reads with and without line alignment
		// read align only set while line size is 8
		axi_wr(`PMBP_OFS_CFG, 32'h1 << `PMBP_CFG_RDALN);
		run(1'b1, 1, 3);
		check(cnt, 32'd8);
		run(1'b1, 2, 2);
		check(cnt, 32'd8);
		check(m, 1'b0);
		axi_wr(`PMBP_OFS_CFG, 32'h0);
		run(1'b1, 1, 3);
		check(cnt < 8, 1'b1);
		// control fetch starts at the structure base
		@(posedge clock_i) ctl_base <= 30'h0123_4567; ctl_req <= 1'b1;
		@(posedge clock_i) ctl_req <= 1'b0;
		for (int k = 0; k < 20 && !ctl_go; k++) @(posedge clock_i);
		check(ctl_addr, 30'h0123_4567);
		// parity error in a read with response enabled, then disabled
		axi_wr(`PMBP_OFS_CMD, 32'h40);
		@(posedge clock_i) par_err <= 1'b1; par_rd <= 1'b1;
		@(posedge clock_i) par_err <= 1'b0;
		@(posedge clock_i);
		check({perr_n, perr_oe_n}, 2'b00);
		reg_chk(`PMBP_OFS_STAT, 32'h8101, `PMBP_RESP_OK);
		axi_wr(`PMBP_OFS_STAT, 32'h8100);
		reg_chk(`PMBP_OFS_STAT, 32'h0001, `PMBP_RESP_OK);
		axi_wr(`PMBP_OFS_CMD, 32'h0);
		@(posedge clock_i) par_err <= 1'b1;
		@(posedge clock_i) par_err <= 1'b0;
		@(posedge clock_i);
		check(perr_oe_n, 1'b1);
		// clock request: on demand, and always when clock run disabled
		@(posedge clock_i) need_clk <= 1'b1;
		repeat (3) @(posedge clock_i);
		check({clkrun_n, clkrun_oe_n}, 2'b00);
		axi_wr(`PMBP_OFS_CFG, 32'h1 << `PMBP_CFG_CRDIS);
		@(posedge clock_i) need_clk <= 1'b0;
		repeat (3) @(posedge clock_i);
		check(clkrun_oe_n, 1'b0);
		// wake event drives the wake pin until cleared
		@(posedge clock_i) wake <= 1'b1;
		@(posedge clock_i) wake <= 1'b0;
		repeat (2) @(posedge clock_i);
		check({pme_n, pme_oe_n}, 2'b00);
		// the second parity error above came in a read, so status 15 is set again
		reg_chk(`PMBP_OFS_STAT, 32'h8003, `PMBP_RESP_OK);
		axi_wr(`PMBP_OFS_STAT, 32'h2);
		repeat (3) @(posedge clock_i);
		check(pme_oe_n, 1'b1);
		// low power state: no burst, registers still answer
		axi_wr(`PMBP_OFS_PWR, 32'h3);
		@(posedge clock_i) wr_req <= 1'b1; rd_req <= 1'b1;
		repeat (10) @(posedge clock_i);
		check({wr_o.busy, rd_o.busy}, 2'b00);
		reg_chk(`PMBP_OFS_CLS, 32'h8, `PMBP_RESP_OK);
		@(posedge clock_i) wr_req <= 1'b0; rd_req <= 1'b0;
		conclude();
	end
endmodule // testbench
`default_nettype wire
